/* File: design/hpc_pkg.sv */
// shared constants and types for the paced host-port controller
package hpc_pkg;
  // own register map, byte offsets on the AXI4-Lite side
  localparam logic [7:0] REG_CMD    = 8'h00; // command, write starts an access
  localparam logic [7:0] REG_WDATA  = 8'h04; // data for a device write
  localparam logic [7:0] REG_STATUS = 8'h08; // busy, waiting, done, refused
  localparam logic [7:0] REG_RBUF   = 8'h40; // 16 words of read data
  localparam int         BURST_MAX  = 16;    // words per burst
  // command field positions
  localparam int CMD_WR_BIT   = 8;  // 1 = device write
  localparam int CMD_FSEL_BIT = 9;  // 1 = queue-direct read
  localparam int CMD_BLEN_LSB = 12; // burst length minus one, 4 bits
  // status field positions
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_WAIT_BIT    = 1;
  localparam int ST_DONE_BIT    = 2;
  localparam int ST_REFUSED_BIT = 3;
  // reset values
  localparam logic [15:0] CMD_RST   = 16'h0000;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  // answer codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // device map, byte addresses as seen on the port pins
  localparam logic [7:0] DEV_RXDATA_BASE = 8'h00; // receive data queue window
  localparam logic [7:0] DEV_RXDATA_MASK = 8'he0;
  localparam logic [7:0] DEV_RXSTS       = 8'h40; // receive status queue
  localparam logic [7:0] DEV_TXSTS       = 8'h44; // transmit status queue
  localparam logic [7:0] DEV_IDENT       = 8'h48; // chip_identity
  localparam logic [7:0] DEV_ENDIAN      = 8'h4c; // endian test register
  localparam logic [7:0] DEV_RXLVL       = 8'h50; // receive_queue_level
  localparam logic [7:0] DEV_TXLVL       = 8'h54; // transmit_queue_level
  localparam logic [7:0] DEV_PMGMT       = 8'h58; // power_mgmt_control
  localparam logic [7:0] DEV_FREERUN     = 8'h5c; // free-running counter
  localparam logic [7:0] DEV_DROP        = 8'h60; // dropped-frame counter
  localparam logic [7:0] DEV_RDPCTRL     = 8'h64; // receive_datapath_control
  // times in ns, counts derived from the 100 MHz clock
  localparam int CLK_NS        = 10;
  localparam int T_CYCLE_NS    = 165; // least access cycle
  localparam int T_ASSERT_NS   = 32;  // least strobe low time
  localparam int T_DEASSERT_NS = 13;  // least strobe high time
  localparam int GAP_SHORT_NS  = 165;
  localparam int GAP_LONG_NS   = 330;
  localparam logic [5:0] CYCLE_CYC     = 6'((T_CYCLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] ASSERT_CYC    = 6'((T_ASSERT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] DEASSERT_CYC  = 6'((T_DEASSERT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] GAP_SHORT_CYC = 6'((GAP_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] GAP_LONG_CYC  = 6'((GAP_LONG_NS + CLK_NS - 1) / CLK_NS);
  // gap timers, one per kind of earlier access
  localparam int TM_WR   = 0; // any write
  localparam int TM_RXQ  = 1; // receive data or status queue read
  localparam int TM_TXS  = 2; // transmit status queue read
  localparam int TM_DROP = 3; // dropped-frame counter read
  localparam int TM_RDP  = 4; // datapath control read
  localparam int TM_N    = 5;
  // access sequencer phases
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_WAIT    = 4'b0010,
    ST_ACTIVE  = 4'b0100,
    ST_RECOVER = 4'b1000
  } phase_t;
endpackage

/* File: design/host_port_pacer.sv */
// paced host controller: AXI4-Lite commands in, 16-bit asynchronous port pins out
//
// Summary of operation
// - single, burst, queue-direct reads and single writes issued
// - most registers wait 165 ns after writes
// - power and free-run counter wait 330 ns
// - every gap is filled by a plain stall, no dummy endian reads
// - shorter stall if elapsed time suffices
// - receive level waits after receive data read
// - receive level waits after receive status read
// - transmit level waits after transmit status read
// - dropped counter waits 330 ns after itself
// - status queue waits 330 ns after datapath read
// - bursts up to 16 words, strobe rises after
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module host_port_pacer (
  input  logic        clk,
  input  logic        rst_b,
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  output logic        chip_select_n,
  output logic        read_strobe_n,
  output logic        write_strobe_n,
  output logic [7:1]  dev_addr,
  output logic        queue_direct_sel,
  output logic [15:0] dev_data_out,
  output logic        dev_data_oe,
  input  logic [15:0] dev_data_in
);

  // byte-lane merge for the low half of a register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // reads that pull from the receive data queue
  function automatic logic is_rxdata(input logic [7:0] a, input logic fs);
    return fs || ((a & hpc_pkg::DEV_RXDATA_MASK) == hpc_pkg::DEV_RXDATA_BASE);
  endfunction

  // cycles that timer idx must show before this access may start
  function automatic logic [5:0] need_cyc(input logic [7:0] a, input logic fs,
                                          input logic wr, input int idx);
    logic [5:0] n;
    n = 6'h00;
    if (!wr) begin
      case (idx)
        hpc_pkg::TM_WR: begin
          if (a == hpc_pkg::DEV_PMGMT || a == hpc_pkg::DEV_FREERUN)
            n = hpc_pkg::GAP_LONG_CYC;
          else if (!is_rxdata(a, fs) && a != hpc_pkg::DEV_IDENT && a != hpc_pkg::DEV_ENDIAN
                   && a != hpc_pkg::DEV_RXLVL && a != hpc_pkg::DEV_DROP)
            n = hpc_pkg::GAP_SHORT_CYC;
        end
        hpc_pkg::TM_RXQ:
          if (!fs && a == hpc_pkg::DEV_RXLVL) n = hpc_pkg::GAP_SHORT_CYC;
        hpc_pkg::TM_TXS:
          if (!fs && a == hpc_pkg::DEV_TXLVL) n = hpc_pkg::GAP_SHORT_CYC;
        hpc_pkg::TM_DROP:
          if (!fs && a == hpc_pkg::DEV_DROP) n = hpc_pkg::GAP_LONG_CYC;
        hpc_pkg::TM_RDP:
          if (!fs && a == hpc_pkg::DEV_RXSTS) n = hpc_pkg::GAP_LONG_CYC;
        default: n = 6'h00;
      endcase
    end
    return n;
  endfunction

  // bus side state
  logic        aw_full_ff, nxt_aw_full;   // write address held
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic        w_full_ff, nxt_w_full;     // write data held
  logic [31:0] wbuf_ff, nxt_wbuf;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        awready_ff, nxt_awready;
  logic        wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [15:0] cmd_ff, nxt_cmd;           // last accepted command
  logic [15:0] wdata_ff, nxt_wdata;       // drives the data pins
  logic        refused_ff, nxt_refused;   // command came while busy
  logic        cmd_go;                    // one-cycle start pulse
  // sequencer state
  hpc_pkg::phase_t state_ff, nxt_state;
  logic [5:0]  cnt_ff, nxt_cnt;           // cycles in current phase
  logic [3:0]  beat_ff, nxt_beat;         // word index in a burst
  logic [3:0]  blen_ff, nxt_blen;         // burst length minus one
  logic [7:0]  addr_ff, nxt_addr;
  logic        wr_ff, nxt_wr;
  logic        fsel_ff, nxt_fsel;
  logic        done_ff, nxt_done;
  logic        cs_n_ff, nxt_cs_n;
  logic        rd_n_ff, nxt_rd_n;
  logic        wr_n_ff, nxt_wr_n;
  logic        qsel_ff, nxt_qsel;
  logic        oe_ff, nxt_oe;
  logic [15:0] rbuf_ff [hpc_pkg::BURST_MAX];
  logic [15:0] nxt_rbuf [hpc_pkg::BURST_MAX];
  logic [5:0]  tmr_ff [hpc_pkg::TM_N];    // cycles since each kind of access ended
  logic [5:0]  nxt_tmr [hpc_pkg::TM_N];
  logic        gap_ok;
  logic [5:0]  beat_len;
  logic [5:0]  rec_len;
  logic        commit;

  // bus side: hold address and data until both are in, then commit
  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_full  = w_full_ff;
    nxt_wbuf    = wbuf_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_cmd     = cmd_ff;
    nxt_wdata   = wdata_ff;
    nxt_refused = refused_ff;
    cmd_go      = 1'b0;
    commit      = aw_full_ff && w_full_ff && !bvalid_ff;
    if (awvalid && awready_ff) begin
      nxt_aw_full = 1'b1;
      nxt_awaddr  = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_full = 1'b1;
      nxt_wbuf   = wdata;
      nxt_wstrb  = wstrb;
    end
    if (bvalid_ff && bready) nxt_bvalid = 1'b0;
    // every committed write is answered okay; unmapped writes are dropped
    if (commit) begin
      nxt_aw_full = 1'b0;
      nxt_w_full  = 1'b0;
      nxt_bvalid  = 1'b1;
      case ({awaddr_ff[7:2], 2'b00})
        hpc_pkg::REG_CMD: begin
          // a busy sequencer cannot take a new order; flag it instead
          if (state_ff == hpc_pkg::ST_IDLE) begin
            nxt_cmd     = merge16(cmd_ff, wbuf_ff, wstrb_ff);
            cmd_go      = 1'b1;
            nxt_refused = 1'b0;
          end else begin
            nxt_refused = 1'b1;
          end
        end
        hpc_pkg::REG_WDATA: nxt_wdata = merge16(wdata_ff, wbuf_ff, wstrb_ff);
        default: nxt_wdata = wdata_ff;
      endcase
    end
    if (rvalid_ff && rready) nxt_rvalid = 1'b0;
    // read decode, buffer window first
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = hpc_pkg::RESP_OKAY;
      if (araddr[7:6] == hpc_pkg::REG_RBUF[7:6]) begin
        nxt_rdata = {16'h0000, rbuf_ff[araddr[5:2]]};
      end else begin
        case ({araddr[7:2], 2'b00})
          hpc_pkg::REG_CMD:    nxt_rdata = {16'h0000, cmd_ff};
          hpc_pkg::REG_WDATA:  nxt_rdata = {16'h0000, wdata_ff};
          hpc_pkg::REG_STATUS: nxt_rdata = {28'h0000000, refused_ff, done_ff,
                                            state_ff == hpc_pkg::ST_WAIT,
                                            state_ff != hpc_pkg::ST_IDLE};
          default: begin
            nxt_rdata = 32'h00000000;
            nxt_rresp = hpc_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    nxt_awready = !nxt_aw_full && !nxt_bvalid;
    nxt_wready  = !nxt_w_full && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // bus side registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
      w_full_ff  <= 1'b0;
      wbuf_ff    <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= hpc_pkg::RESP_OKAY;
      cmd_ff     <= hpc_pkg::CMD_RST;
      wdata_ff   <= hpc_pkg::WDATA_RST;
      refused_ff <= 1'b0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      awaddr_ff  <= nxt_awaddr;
      w_full_ff  <= nxt_w_full;
      wbuf_ff    <= nxt_wbuf;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      cmd_ff     <= nxt_cmd;
      wdata_ff   <= nxt_wdata;
      refused_ff <= nxt_refused;
    end
  end

  // sequencer: wait for every gap, hold strobes low, then recover
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_beat  = beat_ff;
    nxt_blen  = blen_ff;
    nxt_addr  = addr_ff;
    nxt_wr    = wr_ff;
    nxt_fsel  = fsel_ff;
    nxt_done  = done_ff;
    nxt_rbuf  = rbuf_ff;
    gap_ok    = 1'b1;
    // bursts step every full cycle; a lone access only needs its low time
    beat_len  = (blen_ff != 4'h0) ? hpc_pkg::CYCLE_CYC : hpc_pkg::ASSERT_CYC;
    rec_len   = (blen_ff != 4'h0) ? hpc_pkg::DEASSERT_CYC
                                  : hpc_pkg::CYCLE_CYC - hpc_pkg::ASSERT_CYC;
    // timers saturate at the longest gap, so none can wrap to look fresh
    for (int i = 0; i < hpc_pkg::TM_N; i++) begin
      nxt_tmr[i] = (tmr_ff[i] < hpc_pkg::GAP_LONG_CYC) ? tmr_ff[i] + 6'h01 : tmr_ff[i];
      if (tmr_ff[i] < need_cyc(addr_ff, fsel_ff, wr_ff, i)) gap_ok = 1'b0;
    end
    unique case (state_ff)
      hpc_pkg::ST_IDLE: begin
        if (cmd_go) begin
          nxt_addr  = nxt_cmd[7:0];
          nxt_wr    = nxt_cmd[hpc_pkg::CMD_WR_BIT];
          nxt_fsel  = nxt_cmd[hpc_pkg::CMD_FSEL_BIT] && !nxt_cmd[hpc_pkg::CMD_WR_BIT];
          // writes are always single words
          nxt_blen  = nxt_cmd[hpc_pkg::CMD_WR_BIT] ? 4'h0
                                                   : nxt_cmd[hpc_pkg::CMD_BLEN_LSB +: 4];
          nxt_done  = 1'b0;
          nxt_state = hpc_pkg::ST_WAIT;
        end
      end
      hpc_pkg::ST_WAIT: begin
        // plain stall instead of dummy reads: elapsed time alone meets the gap
        if (gap_ok) begin
          nxt_state = hpc_pkg::ST_ACTIVE;
          nxt_cnt   = 6'h00;
          nxt_beat  = 4'h0;
        end
      end
      hpc_pkg::ST_ACTIVE: begin
        if (cnt_ff == beat_len - 6'h01) begin
          nxt_cnt = 6'h00;
          if (!wr_ff) nxt_rbuf[beat_ff] = dev_data_in;
          if (beat_ff == blen_ff) begin
            nxt_state = hpc_pkg::ST_RECOVER;
            // restart the timers that this access arms
            if (wr_ff) begin
              nxt_tmr[hpc_pkg::TM_WR] = 6'h00;
            end else begin
              if (is_rxdata(addr_ff, fsel_ff) || addr_ff == hpc_pkg::DEV_RXSTS)
                nxt_tmr[hpc_pkg::TM_RXQ] = 6'h00;
              if (!fsel_ff && addr_ff == hpc_pkg::DEV_TXSTS)
                nxt_tmr[hpc_pkg::TM_TXS] = 6'h00;
              if (!fsel_ff && addr_ff == hpc_pkg::DEV_DROP)
                nxt_tmr[hpc_pkg::TM_DROP] = 6'h00;
              if (!fsel_ff && addr_ff == hpc_pkg::DEV_RDPCTRL)
                nxt_tmr[hpc_pkg::TM_RDP] = 6'h00;
            end
          end else begin
            // next word of a burst; strobes stay low
            nxt_beat = beat_ff + 4'h1;
            nxt_addr = addr_ff + 8'h02;
          end
        end else begin
          nxt_cnt = cnt_ff + 6'h01;
        end
      end
      hpc_pkg::ST_RECOVER: begin
        if (cnt_ff == rec_len - 6'h01) begin
          nxt_cnt   = 6'h00;
          nxt_done  = 1'b1;
          nxt_state = hpc_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + 6'h01;
        end
      end
    endcase
    // pins follow the next phase so they leave flops in step with it
    nxt_cs_n = (nxt_state != hpc_pkg::ST_ACTIVE);
    nxt_rd_n = !(nxt_state == hpc_pkg::ST_ACTIVE && !nxt_wr);
    nxt_wr_n = !(nxt_state == hpc_pkg::ST_ACTIVE && nxt_wr);
    nxt_oe   = (nxt_state == hpc_pkg::ST_ACTIVE) && nxt_wr;
    nxt_qsel = (nxt_state == hpc_pkg::ST_ACTIVE) && nxt_fsel;
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= hpc_pkg::ST_IDLE;
      cnt_ff   <= 6'h00;
      beat_ff  <= 4'h0;
      blen_ff  <= 4'h0;
      addr_ff  <= 8'h00;
      wr_ff    <= 1'b0;
      fsel_ff  <= 1'b0;
      done_ff  <= 1'b0;
      cs_n_ff  <= 1'b1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      qsel_ff  <= 1'b0;
      oe_ff    <= 1'b0;
      for (int i = 0; i < hpc_pkg::BURST_MAX; i++) rbuf_ff[i] <= 16'h0000;
      // no access has happened yet, so no gap is pending
      for (int i = 0; i < hpc_pkg::TM_N; i++) tmr_ff[i] <= hpc_pkg::GAP_LONG_CYC;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      beat_ff  <= nxt_beat;
      blen_ff  <= nxt_blen;
      addr_ff  <= nxt_addr;
      wr_ff    <= nxt_wr;
      fsel_ff  <= nxt_fsel;
      done_ff  <= nxt_done;
      cs_n_ff  <= nxt_cs_n;
      rd_n_ff  <= nxt_rd_n;
      wr_n_ff  <= nxt_wr_n;
      qsel_ff  <= nxt_qsel;
      oe_ff    <= nxt_oe;
      rbuf_ff  <= nxt_rbuf;
      tmr_ff   <= nxt_tmr;
    end
  end

  // outputs straight from flops, except bresp, which is tied to okay
  assign awready          = awready_ff;
  assign wready           = wready_ff;
  assign bresp            = hpc_pkg::RESP_OKAY;
  assign bvalid           = bvalid_ff;
  assign arready          = arready_ff;
  assign rdata            = rdata_ff;
  assign rresp            = rresp_ff;
  assign rvalid           = rvalid_ff;
  assign chip_select_n    = cs_n_ff;
  assign read_strobe_n    = rd_n_ff;
  assign write_strobe_n   = wr_n_ff;
  assign dev_addr         = addr_ff[7:1];
  assign queue_direct_sel = qsel_ff;
  assign dev_data_out     = wdata_ff;
  assign dev_data_oe      = oe_ff;

endmodule

/* File: tb/hpc_chk_sva.sv */
// pin-side assertion checker for the paced host-port controller
`timescale 1ns/10ps
module hpc_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [7:1]  dev_addr,
  input wire logic        queue_direct_sel,
  input wire logic [15:0] dev_data_out,
  input wire logic        dev_data_oe
);
  logic [5:0] wr_gap_ff;   // cycles since the write strobe was last low
  logic [5:0] nxt_wr_gap;
  logic [5:0] rd_gap_ff;   // cycles since the read strobe was last low
  logic [5:0] nxt_rd_gap;
  logic [7:0] last_rd_ff;  // target of the most recent read word
  logic [7:0] nxt_last_rd;
  logic [7:0] tgt;         // byte address the device really decodes
  logic       free_rd;     // targets readable right after a write
  assign tgt = queue_direct_sel ? 8'h00 : {dev_addr, 1'b0};
  assign free_rd = ((tgt & hpc_pkg::DEV_RXDATA_MASK) == hpc_pkg::DEV_RXDATA_BASE) ||
                   tgt == hpc_pkg::DEV_IDENT || tgt == hpc_pkg::DEV_ENDIAN ||
                   tgt == hpc_pkg::DEV_RXLVL || tgt == hpc_pkg::DEV_DROP;
  // gap trackers saturate so a long idle never wraps into a false short gap
  always_comb begin
    nxt_wr_gap = (wr_gap_ff == 6'h3f) ? wr_gap_ff : wr_gap_ff + 6'h01;
    nxt_rd_gap = (rd_gap_ff == 6'h3f) ? rd_gap_ff : rd_gap_ff + 6'h01;
    nxt_last_rd = last_rd_ff;
    if (!write_strobe_n) nxt_wr_gap = 6'h00;
    if (!read_strobe_n) begin
      nxt_rd_gap = 6'h00;
      nxt_last_rd = tgt;
    end
  end
  // registers start with no pending gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_gap_ff <= 6'h3f;
      rd_gap_ff <= 6'h3f;
      last_rd_ff <= 8'hff;
    end else begin
      wr_gap_ff <= nxt_wr_gap;
      rd_gap_ff <= nxt_rd_gap;
      last_rd_ff <= nxt_last_rd;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_rd_start;
    $fell(read_strobe_n);
  endsequence
  sequence s_rd_low4;
    (!read_strobe_n) [*4];
  endsequence
  AST_RD_LOW_TIME: assert property (s_rd_start |-> s_rd_low4)
    else $error("read strobe low too short");
  AST_STROBE_QUAL: assert property ((!read_strobe_n || !write_strobe_n) |->
    (!chip_select_n && (read_strobe_n || write_strobe_n)))
    else $error("strobe without select or both strobes low");
  AST_OE_WRITE: assert property (dev_data_oe |-> !write_strobe_n)
    else $error("data driven outside a write");
  AST_WR_HOLD: assert property ((!write_strobe_n && $past(!write_strobe_n)) |->
    ($stable(dev_addr) && $stable(dev_data_out)))
    else $error("write address or data moved");
  AST_QSEL_READ: assert property (queue_direct_sel |-> !read_strobe_n)
    else $error("queue select outside a read");
  AST_CS_HIGH: assert property ($rose(chip_select_n) |-> chip_select_n [*2])
    else $error("select high time too short");
  AST_BURST_STEP: assert property ((!read_strobe_n && $past(!read_strobe_n) &&
    !$stable(dev_addr)) |-> dev_addr == $past(dev_addr) + 7'h01)
    else $error("burst address step wrong");
  AST_WR_SHORT: assert property ((s_rd_start ##0 !free_rd) |->
    wr_gap_ff >= hpc_pkg::GAP_SHORT_CYC)
    else $error("read too soon after write");
  AST_WR_LONG: assert property ((s_rd_start ##0 (tgt == hpc_pkg::DEV_PMGMT ||
    tgt == hpc_pkg::DEV_FREERUN)) |-> wr_gap_ff >= hpc_pkg::GAP_LONG_CYC)
    else $error("slow register read too soon after write");
  AST_RXLVL_GAP: assert property ((s_rd_start ##0 (tgt == hpc_pkg::DEV_RXLVL &&
    (last_rd_ff < 8'h20 || last_rd_ff == hpc_pkg::DEV_RXSTS))) |->
    rd_gap_ff >= hpc_pkg::GAP_SHORT_CYC)
    else $error("receive level read too soon");
  AST_TXLVL_GAP: assert property ((s_rd_start ##0 (tgt == hpc_pkg::DEV_TXLVL &&
    last_rd_ff == hpc_pkg::DEV_TXSTS)) |-> rd_gap_ff >= hpc_pkg::GAP_SHORT_CYC)
    else $error("transmit level read too soon");
  AST_DROP_GAP: assert property ((s_rd_start ##0 (tgt == hpc_pkg::DEV_DROP &&
    last_rd_ff == hpc_pkg::DEV_DROP)) |-> rd_gap_ff >= hpc_pkg::GAP_LONG_CYC)
    else $error("dropped counter reread too soon");
  AST_RDP_GAP: assert property ((s_rd_start ##0 (tgt == hpc_pkg::DEV_RXSTS &&
    last_rd_ff == hpc_pkg::DEV_RDPCTRL)) |-> rd_gap_ff >= hpc_pkg::GAP_LONG_CYC)
    else $error("status queue read too soon after datapath read");
endmodule
bind host_port_pacer hpc_chk u_chk (.*);

/* File: tb/hpc_dev_model.sv */
// behavioural model of the device behind the host port
`timescale 1ns/10ps
module hpc_dev_model (
  input  logic        chip_select_n,
  input  logic        read_strobe_n,
  input  logic        write_strobe_n,
  input  logic [7:1]  dev_addr,
  input  logic        queue_direct_sel,
  input  logic [15:0] dev_data_out,
  input  logic        dev_data_oe,
  output logic [15:0] dev_data_in
);
  logic [7:0]  tgt;                  // decoded byte address
  logic [15:0] val;                  // word the device presents
  logic [15:0] hold = 16'h0000;      // last word driven
  logic [15:0] drop_cnt = 16'h0000;  // dropped-frame counter
  logic [15:0] drop_snap = 16'h0000; // counter captured at read start
  logic        was_drop = 1'b0;      // current read targets the counter
  logic [15:0] wr_data = 16'h0000;   // last word written
  logic [7:0]  wr_addr = 8'h00;      // last write address
  logic        act;
  assign act = !chip_select_n && !read_strobe_n;
  assign tgt = queue_direct_sel ? {5'h00, dev_addr[2:1], 1'b0} : {dev_addr, 1'b0};
  // data follows the address at once, so burst words need no wait
  assign val = (tgt == hpc_pkg::DEV_DROP) ? drop_snap : {~tgt, tgt};
  // released bus shows the inverse so a late sample never matches
  assign dev_data_in = act ? val : ~hold;
  // keep what was driven, for the released-bus pattern
  always @* begin
    if (act) begin
      hold = val;
      was_drop = (tgt == hpc_pkg::DEV_DROP);
    end
  end
  // counter snapshot at the start of every read
  always @(posedge act) drop_snap = drop_cnt;
  // reading the counter clears one count worth, modelled as an increment
  always @(negedge act) if (was_drop) drop_cnt = drop_cnt + 16'h0001;
  // write capture while select, strobe and driver are all on
  always @* begin
    if (!chip_select_n && !write_strobe_n && dev_data_oe) begin
      wr_data = dev_data_out;
      wr_addr = {dev_addr, 1'b0};
    end
  end
endmodule

/* File: tb/host_port_pacer_tb_top.sv */
// self-checking bench for the paced host-port controller
`timescale 1ns/10ps
`define CHK(g, e) \
  begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module host_port_pacer_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        chip_select_n, read_strobe_n, write_strobe_n, queue_direct_sel, dev_data_oe;
  logic [7:1]  dev_addr;
  logic [15:0] dev_data_out, dev_data_in;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          drop_exp = 0;
  logic [31:0] rd_d;
  logic [1:0]  rd_r;
  logic [7:0]  pa [5] = '{8'h04, 8'h40, 8'h44, 8'h60, 8'h64}; // side-effect reads
  logic [7:0]  pb [5] = '{8'h50, 8'h50, 8'h54, 8'h60, 8'h40}; // reads that must wait
  logic [7:0]  pw [3] = '{8'h54, 8'h5c, 8'h48}; // reads right after a write
  host_port_pacer u_dut (.*);
  hpc_dev_model u_dev (.*);
  // free-running clock
  always #5 clk = ~clk;
  // verdict and end of run
  task automatic finish_test();
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // one write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        `CHK(bresp, hpc_pkg::RESP_OKAY)
      end
    end while (awvalid || wvalid || bready);
  endtask
  // one read, data and code taken at the handshake edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
      end
    end while (arvalid || rready);
  endtask
  // command word: burst length minus one, queue select, write flag, address
  function automatic logic [15:0] mk(logic [7:0] a, logic wr, logic q, logic [3:0] bl);
    return {bl, 2'b00, q, wr, a};
  endfunction
  // issue a command and poll until the access is done
  task automatic dev_cmd(input logic [15:0] c);
    axi_wr(hpc_pkg::REG_CMD, c);
    rd_d = 32'h0;
    while (rd_d[hpc_pkg::ST_DONE_BIT] !== 1'b1) axi_rd(hpc_pkg::REG_STATUS, rd_d, rd_r);
  endtask
  // single device read checked against the word the device should give
  task automatic chk_rd(input logic [7:0] a, input logic q, input logic [7:0] ea);
    logic [15:0] e;
    e = (ea == hpc_pkg::DEV_DROP) ? 16'(drop_exp) : {~ea, ea};
    if (ea == hpc_pkg::DEV_DROP) drop_exp++;
    dev_cmd(mk(a, 1'b0, q, 4'h0));
    axi_rd(hpc_pkg::REG_RBUF, rd_d, rd_r);
    `CHK(rd_d, {16'h0000, e})
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(hpc_pkg::REG_STATUS, rd_d, rd_r);
    `CHK(rd_d, 32'h0)
    axi_rd(hpc_pkg::REG_CMD, rd_d, rd_r);
    `CHK(rd_d, {16'h0000, hpc_pkg::CMD_RST})
    axi_rd(8'h20, rd_d, rd_r);
    `CHK(rd_r, hpc_pkg::RESP_SLVERR)
    axi_wr(hpc_pkg::REG_WDATA, 16'h5a3c);
    dev_cmd(mk(8'h20, 1'b1, 1'b0, 4'h0));
    `CHK(u_dev.wr_data, 16'h5a3c)
    `CHK(u_dev.wr_addr, 8'h20)
    chk_rd(hpc_pkg::DEV_PMGMT, 1'b0, hpc_pkg::DEV_PMGMT);
    for (int i = 0; i < 3; i++) begin
      dev_cmd(mk(8'h24, 1'b1, 1'b0, 4'h0));
      chk_rd(pw[i], 1'b0, pw[i]);
    end
    for (int i = 0; i < 5; i++) begin
      chk_rd(pa[i], 1'b0, pa[i]);
      chk_rd(pb[i], 1'b0, pb[i]);
    end
    dev_cmd(mk(8'h00, 1'b0, 1'b0, 4'hf));
    for (int i = 0; i < hpc_pkg::BURST_MAX; i++) begin
      axi_rd(hpc_pkg::REG_RBUF + 8'(4 * i), rd_d, rd_r);
      `CHK(rd_d, {16'h0000, ~8'(2 * i), 8'(2 * i)})
    end
    chk_rd(8'h56, 1'b1, 8'h06);
    axi_wr(hpc_pkg::REG_CMD, mk(hpc_pkg::DEV_IDENT, 1'b0, 1'b0, 4'h0));
    axi_wr(hpc_pkg::REG_CMD, mk(hpc_pkg::DEV_ENDIAN, 1'b0, 1'b0, 4'h0));
    axi_rd(hpc_pkg::REG_STATUS, rd_d, rd_r);
    `CHK(rd_d[hpc_pkg::ST_REFUSED_BIT], 1'b1)
    while (rd_d[hpc_pkg::ST_DONE_BIT] !== 1'b1) axi_rd(hpc_pkg::REG_STATUS, rd_d, rd_r);
    chk_rd(hpc_pkg::DEV_ENDIAN, 1'b0, hpc_pkg::DEV_ENDIAN);
    finish_test();
  end
endmodule
